// ---- hdl/fbpu_pkg.sv ----
// constants, register map and state encoding of the flash block protection unit
// assumes one 20 MHz system clock and word-wide register and memory accesses
package fbpu_pkg;

    // ==========================================================
    // clock and memory map
    localparam int          CLK_MHZ           = 20;
    localparam logic [31:0] SRAM_BASE         = 32'h2000_0000;
    localparam logic [31:0] ALIAS_BASE        = 32'h2200_0000;
    localparam int          SRAM_BYTES        = 8192;
    localparam int          FLASH_BYTES       = 65536;
    localparam int          ALIAS_BYTE_SCALE  = 32;
    localparam int          ALIAS_BIT_SCALE   = 4;
    localparam logic [31:0] ALIAS_SPAN        = 32'(SRAM_BYTES * ALIAS_BYTE_SCALE);
    localparam int          ERASE_BLOCK_BYTES = 1024;
    localparam int          PROT_BLOCK_BYTES  = 2048;
    localparam int          SRAM_WORDS        = SRAM_BYTES / 4;
    localparam int          FLASH_WORDS       = FLASH_BYTES / 4;
    localparam int          ERASE_WORDS       = ERASE_BLOCK_BYTES / 4;
    localparam int          PROT_BLOCKS       = FLASH_BYTES / PROT_BLOCK_BYTES;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFF_FLASH_ADDRESS   = 8'h00;
    localparam logic [7:0] OFF_FLASH_DATA      = 8'h04;
    localparam logic [7:0] OFF_FLASH_CONTROL   = 8'h08;
    localparam logic [7:0] OFF_RAW_IRQ_STATUS  = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK        = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS_CLR  = 8'h14;
    localparam logic [7:0] OFF_PROGRAM_ENABLE  = 8'h18;
    localparam logic [7:0] OFF_READ_ENABLE     = 8'h1C;
    localparam logic [7:0] OFF_USEC_RELOAD     = 8'h20;

    // ==========================================================
    // fields
    localparam int FC_WRITE_BIT    = 0;
    localparam int FC_ERASE_BIT    = 1;
    localparam int FC_COMMIT_BIT   = 3;
    localparam int IRQ_PROG_BIT    = 0;
    localparam int IRQ_ACCESS_BIT  = 1;
    localparam int FA_COMMIT_SEL   = 0;

    // ==========================================================
    // reset values and timing
    localparam logic [31:0] PROT_RST         = 32'hFFFF_FFFF;
    localparam logic [7:0]  USEC_RELOAD_RST  = 8'(CLK_MHZ - 1);
    localparam logic [7:0]  PROG_TIME_US     = 8'h14;
    localparam logic [7:0]  ERASE_TIME_US    = 8'h32;
    localparam logic [7:0]  COMMIT_TIME_US   = 8'h32;

    typedef enum logic [1:0] {
        FBPU_IDLE = 2'b01,
        FBPU_BUSY = 2'b10
    } fbpu_state_t;

endpackage

// ---- hdl/fbpu_top.sv ----
// flash block protection unit: sram with bit-band alias, flash array with
// per-2KB protection, flash controller registers and microsecond timebase
// assumes masters issue single-word accesses and take the answer next cycle
// Function
// - SRAM is decoded from base address 0x2000_0000.
// - each alias word maps to one bit: base + byte*32 + bit*4.
// - alias region starts at 0x2200_0000 for SRAM byte offset zero.
// - alias read or write touches only its target bit, atomically.
// - erase works on 1 KB blocks and sets every bit to one.
// - programming a word only clears bits, never sets them.
// - protection per 2 KB block, program and read enable in 32-bit registers.
// - program-enable zero forbids any change to the block.
// - read-enable zero serves instruction fetches only, blocks data reads.
// - blocked data read returns no data and signals a bus fault.
// - program or erase on protected block refused, access interrupt if masked in.
// - all enable bits are one as delivered.
// - bits only clear; uncommitted clears undone by reset; commits permanent.
// - nonvolatile protection is written only on a software commit.
// - literal loads are checked like any other data read.
// - microsecond reload resets to a value safe at maximum clock.
// - program and erase times count configured cycles per microsecond.
// - writing one to status clear clears raw and masked interrupt.
`timescale 1ns/1ps
`default_nettype none
module fbpu_top (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    // register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [31:0] o_reg_rdata,
    // memory access port
    input  wire logic        i_acc_valid,
    input  wire logic        i_acc_write,
    input  wire logic        i_acc_fetch,
    input  wire logic [31:0] i_acc_addr,
    input  wire logic [31:0] i_acc_wdata,
    output logic             o_acc_ready,
    output logic             o_acc_fault,
    output logic      [31:0] o_acc_rdata,
    // interrupt
    output logic             o_flash_irq
);

    // ==========================================================
    // state
    logic [31:0] sram [0:fbpu_pkg::SRAM_WORDS-1];
    logic [31:0] flash [0:fbpu_pkg::FLASH_WORDS-1];
    // nonvolatile copies survive i_nrst; only a commit lowers them
    logic [31:0] nv_program_enable = fbpu_pkg::PROT_RST;
    logic [31:0] nv_read_enable    = fbpu_pkg::PROT_RST;

    logic [31:0]           flash_address;
    logic [31:0]           flash_data;
    logic [31:0]           block_program_enable;
    logic [31:0]           block_read_enable;
    logic                  nv_loaded;
    logic [7:0]            microsecond_reload;
    logic [7:0]            usec_count;
    logic [7:0]            us_left;
    logic [1:0]            flash_raw_irq_status;
    logic [1:0]            flash_irq_mask;
    logic [3:0]            op_bits;
    fbpu_pkg::fbpu_state_t state;

    // ==========================================================
    // register decode
    wire wr_fa   = i_reg_wr && (i_reg_addr == fbpu_pkg::OFF_FLASH_ADDRESS);
    wire wr_fd   = i_reg_wr && (i_reg_addr == fbpu_pkg::OFF_FLASH_DATA);
    wire wr_fc   = i_reg_wr && (i_reg_addr == fbpu_pkg::OFF_FLASH_CONTROL);
    wire wr_mask = i_reg_wr && (i_reg_addr == fbpu_pkg::OFF_IRQ_MASK);
    wire wr_clr  = i_reg_wr && (i_reg_addr == fbpu_pkg::OFF_IRQ_STATUS_CLR);
    wire wr_pe   = i_reg_wr && (i_reg_addr == fbpu_pkg::OFF_PROGRAM_ENABLE);
    wire wr_re   = i_reg_wr && (i_reg_addr == fbpu_pkg::OFF_READ_ENABLE);
    wire wr_usec = i_reg_wr && (i_reg_addr == fbpu_pkg::OFF_USEC_RELOAD);

    wire [1:0] masked_status = flash_raw_irq_status & flash_irq_mask;
    logic [31:0] reg_mux;
    always_comb begin
        unique case (i_reg_addr)
            fbpu_pkg::OFF_FLASH_ADDRESS:  reg_mux = flash_address;
            fbpu_pkg::OFF_FLASH_DATA:     reg_mux = flash_data;
            fbpu_pkg::OFF_FLASH_CONTROL:  reg_mux = {28'h0000000, op_bits};
            fbpu_pkg::OFF_RAW_IRQ_STATUS: reg_mux = {30'h00000000, flash_raw_irq_status};
            fbpu_pkg::OFF_IRQ_MASK:       reg_mux = {30'h00000000, flash_irq_mask};
            fbpu_pkg::OFF_IRQ_STATUS_CLR: reg_mux = {30'h00000000, masked_status};
            fbpu_pkg::OFF_PROGRAM_ENABLE: reg_mux = block_program_enable;
            fbpu_pkg::OFF_READ_ENABLE:    reg_mux = block_read_enable;
            fbpu_pkg::OFF_USEC_RELOAD:    reg_mux = {24'h000000, microsecond_reload};
            default:                      reg_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // control write fields
    wire        fc_write   = i_reg_wdata[fbpu_pkg::FC_WRITE_BIT];
    wire        fc_erase   = i_reg_wdata[fbpu_pkg::FC_ERASE_BIT];
    wire        fc_commit  = i_reg_wdata[fbpu_pkg::FC_COMMIT_BIT];

    // ==========================================================
    // flash operation decode
    wire [4:0]  op_block   = flash_address[15:11];
    wire [5:0]  erase_page = flash_address[15:10];
    wire [13:0] prog_word  = flash_address[15:2];
    wire        op_allowed = block_program_enable[op_block];
    wire        req_change = wr_fc && (fc_write || fc_erase);
    wire        req_commit = wr_fc && fc_commit;
    wire        is_idle    = (state == fbpu_pkg::FBPU_IDLE);
    // control writes while busy are dropped, not queued
    wire        refused    = is_idle && req_change && !op_allowed;
    wire        start      = is_idle && ((req_change && op_allowed) || req_commit);
    wire        us_tick    = (usec_count == 8'h00);
    wire        op_done    = (state == fbpu_pkg::FBPU_BUSY) && us_tick && (us_left == 8'h00);
    wire [7:0]  start_time = req_commit ? fbpu_pkg::COMMIT_TIME_US :
                             fc_erase ? fbpu_pkg::ERASE_TIME_US :
                             fbpu_pkg::PROG_TIME_US;
    wire [3:0]  start_bits = req_commit ? 4'h8 :
                             fc_erase ? 4'h2 : 4'h1;
    wire        done_write  = op_done && op_bits[fbpu_pkg::FC_WRITE_BIT];
    wire        done_erase  = op_done && op_bits[fbpu_pkg::FC_ERASE_BIT];
    wire        done_commit = op_done && op_bits[fbpu_pkg::FC_COMMIT_BIT];
    wire        commit_pe   = flash_address[fbpu_pkg::FA_COMMIT_SEL];

    wire [1:0] irq_set;
    assign irq_set[fbpu_pkg::IRQ_PROG_BIT]   = op_done;
    assign irq_set[fbpu_pkg::IRQ_ACCESS_BIT] = refused;
    wire [1:0] irq_clr = wr_clr ? i_reg_wdata[1:0] : 2'b00;
    // set wins over a clear arriving in the same cycle
    wire [1:0] next_raw = (flash_raw_irq_status & ~irq_clr) | irq_set;

    // ==========================================================
    // memory access decode
    wire [31:0] sram_off  = i_acc_addr - fbpu_pkg::SRAM_BASE;
    wire [31:0] alias_off = i_acc_addr - fbpu_pkg::ALIAS_BASE;
    wire        in_sram   = sram_off < 32'(fbpu_pkg::SRAM_BYTES);
    wire        in_alias  = alias_off < fbpu_pkg::ALIAS_SPAN;
    wire        in_flash  = i_acc_addr < 32'(fbpu_pkg::FLASH_BYTES);
    wire [12:0] al_byte   = alias_off[17:5];
    wire [2:0]  al_bit    = alias_off[4:2];
    wire [10:0] al_word   = al_byte[12:2];
    wire [4:0]  al_pos    = {al_byte[1:0], al_bit};
    wire [10:0] sram_word = sram_off[12:2];
    wire [13:0] fl_word   = i_acc_addr[15:2];
    // literal loads come as data reads, so only a fetch bypasses read protection
    wire        fl_rd_ok  = i_acc_fetch || block_read_enable[i_acc_addr[15:11]];
    // flash is changed only through the controller, so bus writes fault
    wire        acc_fault = i_acc_valid && !(in_sram || in_alias ||
                            (in_flash && !i_acc_write && fl_rd_ok));
    // reads during a flash operation see the old contents, no stall
    wire [31:0] acc_data  = acc_fault || i_acc_write ? 32'h0000_0000 :
                            in_sram  ? sram[sram_word] :
                            in_alias ? {31'h00000000, sram[al_word][al_pos]} :
                            flash[fl_word];

    // ==========================================================
    // memories, no reset
    always_ff @(posedge i_ref_clk) begin
        if (i_acc_valid && i_acc_write && in_sram) begin
            sram[sram_word] <= i_acc_wdata;
        end
        if (i_acc_valid && i_acc_write && in_alias) begin
            sram[al_word][al_pos] <= i_acc_wdata[0];
        end
        if (done_write) begin
            flash[prog_word] <= flash[prog_word] & flash_data;
        end
        if (done_erase) begin
            for (int w = 0; w < fbpu_pkg::ERASE_WORDS; w++) begin
                flash[{erase_page, 8'(w)}] <= 32'hFFFF_FFFF;
            end
        end
        // commit only lowers nv bits, so a committed clear never comes back
        if (done_commit && commit_pe) begin
            nv_program_enable <= nv_program_enable & block_program_enable;
        end
        if (done_commit && !commit_pe) begin
            nv_read_enable <= nv_read_enable & block_read_enable;
        end
    end

    // ==========================================================
    // protection registers
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            block_program_enable <= fbpu_pkg::PROT_RST;
            block_read_enable    <= fbpu_pkg::PROT_RST;
            nv_loaded            <= 1'b0;
        end else if (!nv_loaded) begin
            // committed clears come back one cycle after release
            block_program_enable <= nv_program_enable;
            block_read_enable    <= nv_read_enable;
            nv_loaded            <= 1'b1;
        end else begin
            if (wr_pe) begin
                block_program_enable <= block_program_enable & i_reg_wdata;
            end
            if (wr_re) begin
                block_read_enable <= block_read_enable & i_reg_wdata;
            end
        end
    end

    // ==========================================================
    // controller registers and timebase
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flash_address        <= 32'h0000_0000;
            flash_data           <= 32'h0000_0000;
            microsecond_reload   <= fbpu_pkg::USEC_RELOAD_RST;
            flash_irq_mask       <= 2'b00;
        end else begin
            if (wr_fa) begin
                flash_address <= i_reg_wdata;
            end
            if (wr_fd) begin
                flash_data <= i_reg_wdata;
            end
            if (wr_usec) begin
                microsecond_reload <= i_reg_wdata[7:0];
            end
            if (wr_mask) begin
                flash_irq_mask <= i_reg_wdata[1:0];
            end
        end
    end

    // ==========================================================
    // microsecond timebase
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            usec_count <= fbpu_pkg::USEC_RELOAD_RST;
        end else begin
            // a new reload applies from the next wrap; a running count is not cut short
            usec_count <= us_tick ? microsecond_reload : usec_count - 8'h01;
        end
    end

    // ==========================================================
    // interrupt status
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flash_raw_irq_status <= 2'b00;
        end else begin
            flash_raw_irq_status <= next_raw;
        end
    end

    // ==========================================================
    // operation sequencer
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state   <= fbpu_pkg::FBPU_IDLE;
            us_left <= 8'h00;
            op_bits <= 4'h0;
        end else begin
            unique case (state)
                fbpu_pkg::FBPU_IDLE: begin
                    if (start) begin
                        state   <= fbpu_pkg::FBPU_BUSY;
                        us_left <= start_time;
                        op_bits <= start_bits;
                    end
                end
                fbpu_pkg::FBPU_BUSY: begin
                    if (op_done) begin
                        state   <= fbpu_pkg::FBPU_IDLE;
                        op_bits <= 4'h0;
                    end else if (us_tick) begin
                        us_left <= us_left - 8'h01;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= 32'h0000_0000;
            o_acc_ready <= 1'b0;
            o_acc_fault <= 1'b0;
            o_acc_rdata <= 32'h0000_0000;
            o_flash_irq <= 1'b0;
        end else begin
            o_reg_rdata <= i_reg_rd ? reg_mux : 32'h0000_0000;
            o_acc_ready <= i_acc_valid;
            o_acc_fault <= acc_fault;
            o_acc_rdata <= acc_data;
            o_flash_irq <= |(next_raw & flash_irq_mask);
        end
    end

endmodule
`default_nettype wire

// ---- tb/fbpu_chk.sv ----
// timing and decode checks on the memory access port of the protection unit
// assumes binding into fbpu_top, one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module fbpu_chk (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    // memory access port
    input  wire logic        i_acc_valid,
    input  wire logic        i_acc_write,
    input  wire logic        i_acc_fetch,
    input  wire logic [31:0] i_acc_addr,
    input  wire logic        o_acc_ready,
    input  wire logic        o_acc_fault,
    input  wire logic [31:0] o_acc_rdata
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    // ==========================================================
    // request shapes
    sequence s_rd(lo, hi);
        i_acc_valid && !i_acc_write && i_acc_addr >= lo && i_acc_addr < hi;
    endsequence

    // ==========================================================
    // assertions
    ready_next_a: assert property (i_acc_valid |=> o_acc_ready)
        else $error("ready missing after request");
    ready_cause_a: assert property (o_acc_ready |-> $past(i_acc_valid))
        else $error("ready without request");
    fault_pulse_a: assert property (o_acc_fault |-> o_acc_ready)
        else $error("fault outside ready");
    fault_zero_a: assert property (o_acc_fault |-> o_acc_rdata == 32'h0)
        else $error("faulted read returned data");
    sram_ok_a: assert property (s_rd(32'h2000_0000, 32'h2000_2000) |=> !o_acc_fault)
        else $error("sram read faulted");
    alias_bit_a: assert property (s_rd(32'h2200_0000, 32'h2204_0000) |=> !o_acc_fault && o_acc_rdata[31:1] == 31'h0)
        else $error("alias read not a single bit");
    fetch_ok_a: assert property (s_rd(32'h0, 32'h1_0000) ##0 i_acc_fetch |=> !o_acc_fault)
        else $error("flash fetch faulted");
    hole_fault_a: assert property (i_acc_valid && i_acc_addr[31:28] == 4'h3 |=> o_acc_fault)
        else $error("unmapped access served");
endmodule
bind fbpu_top fbpu_chk i_chk (.i_ref_clk, .i_nrst, .i_acc_valid, .i_acc_write, .i_acc_fetch, .i_acc_addr,
    .o_acc_ready, .o_acc_fault, .o_acc_rdata);
`default_nettype wire

// ---- tb/fbpu_bus_master.sv ----
// model of the processor bus master issuing single-word memory accesses
// assumes the unit answers exactly one cycle after the request pulse
`timescale 1ns/1ps
`default_nettype none
module fbpu_bus_master (
    // clock
    input  wire logic        i_ref_clk,
    // request toward the unit
    output logic             o_acc_valid,
    output logic             o_acc_write,
    output logic             o_acc_fetch,
    output logic      [31:0] o_acc_addr,
    output logic      [31:0] o_acc_wdata,
    // answer from the unit
    input  wire logic        i_acc_ready,
    input  wire logic        i_acc_fault,
    input  wire logic [31:0] i_acc_rdata
);
    initial begin
        o_acc_valid = 1'b0;
        o_acc_write = 1'b0;
        o_acc_fetch = 1'b0;
        o_acc_addr  = 32'h0;
        o_acc_wdata = 32'h0;
    end

    task automatic access(input logic wr, fe, input logic [31:0] a, d, output logic [31:0] q,
                          output logic [1:0] s);
        @(posedge i_ref_clk);
        o_acc_valid <= 1'b1;
        o_acc_write <= wr;
        o_acc_fetch <= fe;
        o_acc_addr  <= a;
        o_acc_wdata <= d;
        @(posedge i_ref_clk);
        // released lines flip so a stale value is never mistaken for a request
        o_acc_valid <= 1'b0;
        o_acc_addr  <= ~a;
        o_acc_wdata <= ~d;
        @(posedge i_ref_clk);
        q = i_acc_rdata;
        s = {i_acc_ready, i_acc_fault};
    endtask
endmodule
`default_nettype wire

// ---- tb/fbpu_top_tb.sv ----
// self-checking bench of the flash block protection unit
// assumes the bus master model drives the memory port, registers driven here
`timescale 1ns/1ps
`default_nettype none
module fbpu_top_tb;
    logic        i_ref_clk;
    logic        i_nrst;
    logic [7:0]  i_reg_addr;
    logic [31:0] i_reg_wdata;
    logic        i_reg_wr;
    logic        i_reg_rd;
    logic [31:0] o_reg_rdata;
    logic        acc_valid, acc_write, acc_fetch, acc_ready, acc_fault, o_flash_irq;
    logic [31:0] acc_addr, acc_wdata, acc_rdata, q;
    logic [1:0]  st;
    int          err_count;
    int          checks;
    int          n;

    fbpu_top i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_acc_valid(acc_valid),
        .i_acc_write(acc_write), .i_acc_fetch(acc_fetch), .i_acc_addr(acc_addr), .i_acc_wdata(acc_wdata),
        .o_acc_ready(acc_ready), .o_acc_fault(acc_fault), .o_acc_rdata(acc_rdata), .o_flash_irq(o_flash_irq));
    fbpu_bus_master i_bus (.i_ref_clk(i_ref_clk), .o_acc_valid(acc_valid), .o_acc_write(acc_write),
        .o_acc_fetch(acc_fetch), .o_acc_addr(acc_addr), .o_acc_wdata(acc_wdata), .i_acc_ready(acc_ready),
        .i_acc_fault(acc_fault), .i_acc_rdata(acc_rdata));

    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_ref_clk);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        @(posedge i_ref_clk);
        chk(o_reg_rdata, e);
    endtask
    task automatic expect_acc(input logic wr, fe, input logic [31:0] a, d, e, input logic [1:0] s);
        i_bus.access(wr, fe, a, d, q, st);
        chk(q, e);
        chk({30'h0, st}, {30'h0, s});
    endtask
    // polls control until idle; poll count is the only timing view software has
    task automatic wait_idle();
        for (n = 0; n < 1000; n++) begin
            i_bus.access(1'b0, 1'b0, 32'h2000_0000, 32'h0, q, st);
            i_reg_rd   <= 1'b1;
            i_reg_addr <= fbpu_pkg::OFF_FLASH_CONTROL;
            @(posedge i_ref_clk);
            i_reg_rd <= 1'b0;
            @(posedge i_ref_clk);
            if (o_reg_rdata === 32'h0) return;
        end
        err_count++;
        report_and_stop();
    endtask
    task automatic do_reset();
        i_nrst <= 1'b0;
        repeat (12) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
    endtask
    task automatic flash_op(input logic [31:0] a, d, c);
        reg_wr(fbpu_pkg::OFF_FLASH_ADDRESS, a);
        reg_wr(fbpu_pkg::OFF_FLASH_DATA, d);
        reg_wr(fbpu_pkg::OFF_FLASH_CONTROL, c);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset_values();
        expect_reg(fbpu_pkg::OFF_PROGRAM_ENABLE, 32'hFFFF_FFFF);
        expect_reg(fbpu_pkg::OFF_READ_ENABLE, 32'hFFFF_FFFF);
        expect_reg(fbpu_pkg::OFF_USEC_RELOAD, 32'h0000_0013);
        expect_reg(8'h40, 32'h0);
    endtask
    task automatic t_sram_alias();
        expect_acc(1'b1, 1'b0, 32'h2000_1000, 32'hFFFF_FFFF, 32'h0, 2'b10);
        expect_acc(1'b1, 1'b0, 32'h2202_000C, 32'h0, 32'h0, 2'b10);
        expect_acc(1'b0, 1'b0, 32'h2000_1000, 32'h0, 32'hFFFF_FFF7, 2'b10);
        expect_acc(1'b0, 1'b0, 32'h2202_000C, 32'h0, 32'h0, 2'b10);
        expect_acc(1'b0, 1'b0, 32'h2202_0010, 32'h0, 32'h1, 2'b10);
        expect_acc(1'b0, 1'b0, 32'h3000_0000, 32'h0, 32'h0, 2'b11);
    endtask
    task automatic t_flash();
        flash_op(32'h0, 32'h0, 32'h2);
        wait_idle();
        expect_acc(1'b0, 1'b0, 32'h0, 32'h0, 32'hFFFF_FFFF, 2'b10);
        expect_acc(1'b0, 1'b0, 32'h3FC, 32'h0, 32'hFFFF_FFFF, 2'b10);
        flash_op(32'h0, 32'h0F0F_00FF, 32'h1);
        wait_idle();
        flash_op(32'h0, 32'hFFFF_0000, 32'h1);
        wait_idle();
        expect_acc(1'b0, 1'b0, 32'h0, 32'h0, 32'h0F0F_0000, 2'b10);
        expect_reg(fbpu_pkg::OFF_RAW_IRQ_STATUS, 32'h1);
        reg_wr(fbpu_pkg::OFF_USEC_RELOAD, 32'h9);
        flash_op(32'h4, 32'h1234_5678, 32'h1);
        wait_idle();
        // ten cycles a tick, twenty ticks, five cycles a poll, first tick late by up to twenty cycles
        chk({31'h0, n > 38 && n < 46}, 32'h1);
        expect_acc(1'b0, 1'b0, 32'h4, 32'h0, 32'h1234_5678, 2'b10);
        reg_wr(fbpu_pkg::OFF_USEC_RELOAD, 32'h13);
    endtask
    task automatic t_protect();
        reg_wr(fbpu_pkg::OFF_IRQ_STATUS_CLR, 32'h3);
        reg_wr(fbpu_pkg::OFF_IRQ_MASK, 32'h2);
        reg_wr(fbpu_pkg::OFF_PROGRAM_ENABLE, 32'hFFFF_FFFE);
        flash_op(32'h0, 32'h0, 32'h2);
        expect_reg(fbpu_pkg::OFF_FLASH_CONTROL, 32'h0);
        expect_reg(fbpu_pkg::OFF_RAW_IRQ_STATUS, 32'h2);
        chk({31'h0, o_flash_irq}, 32'h1);
        expect_acc(1'b0, 1'b0, 32'h0, 32'h0, 32'h0F0F_0000, 2'b10);
        reg_wr(fbpu_pkg::OFF_IRQ_STATUS_CLR, 32'h3);
        expect_reg(fbpu_pkg::OFF_RAW_IRQ_STATUS, 32'h0);
        expect_reg(fbpu_pkg::OFF_IRQ_STATUS_CLR, 32'h0);
        chk({31'h0, o_flash_irq}, 32'h0);
    endtask
    task automatic t_read_protect();
        reg_wr(fbpu_pkg::OFF_READ_ENABLE, 32'hFFFF_FFFE);
        expect_acc(1'b0, 1'b0, 32'h0, 32'h0, 32'h0, 2'b11);
        expect_acc(1'b0, 1'b1, 32'h0, 32'h0, 32'h0F0F_0000, 2'b10);
        reg_wr(fbpu_pkg::OFF_READ_ENABLE, 32'hFFFF_FFFF);
        expect_reg(fbpu_pkg::OFF_READ_ENABLE, 32'hFFFF_FFFE);
    endtask
    task automatic t_commit();
        do_reset();
        expect_reg(fbpu_pkg::OFF_PROGRAM_ENABLE, 32'hFFFF_FFFF);
        expect_reg(fbpu_pkg::OFF_READ_ENABLE, 32'hFFFF_FFFF);
        reg_wr(fbpu_pkg::OFF_PROGRAM_ENABLE, 32'hFFFF_FFFD);
        reg_wr(fbpu_pkg::OFF_READ_ENABLE, 32'hFFFF_FFFB);
        flash_op(32'h1, 32'h0, 32'h8);
        wait_idle();
        do_reset();
        expect_reg(fbpu_pkg::OFF_PROGRAM_ENABLE, 32'hFFFF_FFFD);
        expect_reg(fbpu_pkg::OFF_READ_ENABLE, 32'hFFFF_FFFF);
    endtask

    initial begin
        i_nrst      <= 1'b0;
        i_reg_addr  = 8'h0;
        i_reg_wdata = 32'h0;
        i_reg_wr    = 1'b0;
        i_reg_rd    = 1'b0;
        err_count   = 0;
        checks      = 0;
        do_reset();
        t_reset_values();
        t_sram_alias();
        t_flash();
        t_protect();
        t_read_protect();
        t_commit();
        report_and_stop();
    end
endmodule
`default_nettype wire
